//--- pkg/rtc_pkg.sv
// Register map, field positions, reset values and timing counts of the clock calibration block.
package rtc_pkg;

  localparam logic [7:0]  OFF_ALARM_VALUE = 8'h00;
  localparam logic [7:0]  OFF_ALARM_CFG   = 8'h04;
  localparam logic [7:0]  OFF_TIME_VALUE  = 8'h08;
  localparam logic [7:0]  OFF_CFG_TRIM    = 8'h0C;
  localparam logic [7:0]  OFF_PAD         = 8'h10;
  localparam logic [7:0]  OFF_INT_STATUS  = 8'h14;
  localparam logic [7:0]  OFF_INT_MASK    = 8'h18;

  localparam int          B_RUN_EN        = 15;
  localparam int          B_UNLOCK        = 13;
  localparam int          B_PIN_OE        = 10;
  localparam int          B_AL_EN         = 15;
  localparam int          B_CHIME         = 14;
  localparam int          B_SEC_SEL       = 1;
  localparam int          B_LEVEL_SEL     = 0;
  localparam int          I_ALARM         = 0;
  localparam int          I_SECOND        = 1;
  localparam int          I_TRIM          = 2;

  localparam logic [15:0] CFG_TRIM_RST    = 16'h0000;
  localparam logic [15:0] ALARM_CFG_RST   = 16'h0000;
  localparam logic [1:0]  PAD_RST         = 2'h0;
  localparam logic [2:0]  INT_RST         = 3'h0;
  localparam logic [15:0] CFG_WR_MASK     = 16'hA7FF;

  localparam int          OSC_HZ          = 32768;
  localparam int          TRIM_EDGE       = 512;
  localparam int          TRIM_STEP       = 4;
  localparam int          SYNC_EDGES      = 32;
  localparam logic [14:0] PRESC_LAST      = 15'(OSC_HZ - 1);
  localparam logic [14:0] TRIM_AT         = 15'(TRIM_EDGE - 1);
  localparam logic [14:0] TRIM_BASE       = 15'(TRIM_EDGE);
  localparam logic [14:0] SYNC_FROM       = 15'(OSC_HZ - SYNC_EDGES);
  localparam logic [7:0]  SEC_LAST        = 8'h59;

endpackage

//--- pkg/trim_if.sv
// Signals shared between the register core and the trimmed prescaler.
interface trim_if;
  logic       osc_edge;
  logic       run;
  logic       minute_wrap;
  logic [7:0] cal;
  logic       second_tick;
  logic       half_second;
  logic       rollover_pending;
  logic       trim_applied;

  modport core (output osc_edge, run, minute_wrap, cal,
                input  second_tick, half_second, rollover_pending, trim_applied);
  modport presc (input  osc_edge, run, minute_wrap, cal,
                 output second_tick, half_second, rollover_pending, trim_applied);
endinterface

//--- hdl/window_mem.sv
// Small word store behind the alarm and time value windows, with registered read data.
module window_mem (
  input  wire logic        pclk,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  wbe,
  input  wire logic [2:0]  raddr,
  output logic      [15:0] rdata
);
  logic [15:0] mem [8];

  always_ff @(posedge pclk) begin
    if (we && wbe[0]) begin
      mem[waddr][7:0] <= wdata[7:0];
    end
    if (we && wbe[1]) begin
      mem[waddr][15:8] <= wdata[15:8];
    end
  end

  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule

//--- hdl/trim_prescaler.sv
// Oscillator prescaler that makes the seconds tick and applies the per-minute trim.
module trim_prescaler
  import rtc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  trim_if.presc     t
);
  logic [14:0] count;
  logic        armed;
  logic [14:0] next_count;
  logic [9:0]  edges;

  assign t.trim_applied     = t.run && t.osc_edge && armed && count == TRIM_AT;
  assign next_count         = TRIM_BASE + 15'($signed(t.cal) * TRIM_STEP);
  assign t.second_tick      = t.run && t.osc_edge && count == PRESC_LAST;
  assign t.half_second      = count[14];
  assign t.rollover_pending = count >= SYNC_FROM;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 15'h0000;
    end else if (t.trim_applied) begin
      count <= next_count;
    end else if (t.run && t.osc_edge) begin
      count <= count + 15'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (t.minute_wrap) begin
      armed <= 1'b1;
    end else if (t.trim_applied) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges <= 10'h000;
    end else if (t.minute_wrap) begin
      edges <= 10'h000;
    end else if (t.run && t.osc_edge) begin
      edges <= edges + 10'h001;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_trim_edge;
    t.trim_applied |-> edges == 10'h1FF;
  endproperty
  property p_trim_value;
    t.trim_applied |=> count == TRIM_BASE + 15'($signed($past(t.cal)) * TRIM_STEP);
  endproperty
  property p_trim_once;
    t.trim_applied |=> !armed && !t.trim_applied;
  endproperty
  property p_trim_dir;
    t.trim_applied && t.cal != 8'h00 |=> (count > TRIM_BASE) == !$past(t.cal[7]);
  endproperty

  a_trim_edge:  assert property (p_trim_edge) else $error("Trim not on 512th edge.");
  a_trim_value: assert property (p_trim_value) else $error("Trim amount wrong.");
  a_trim_once:  assert property (p_trim_once) else $error("Trim repeated.");
  a_trim_dir:   assert property (p_trim_dir) else $error("Trim direction wrong.");
  c_trim_pos:   cover property (t.trim_applied && !t.cal[7] && t.cal != 8'h00);
  c_trim_neg:   cover property (t.trim_applied && t.cal[7]);
endmodule

//--- hdl/rtc_calib.sv
// Clock calibration core: APB registers, seconds and minutes counting, alarm, pin and interrupts.
// Behaviour
// - Trim at 512th edge after 59-to-00.
// - Sample signed trim field, adjust prescaler.
// - Seconds clock selectable onto clock pin.
// - Counting continues while system sleeps.
// - Enabled alarm interrupt wakes from sleep.
// - Idle mode changes nothing here.
// - Windows undefined, control registers clear.
// - Unimplemented bits read zero (alarm configuration bits 13:10 read back as written).
// - Each trim unit is four cycles.
// - Inserting speeds up, blanking slows down.
//
// The implementer's own choices: register access over APB and the register offsets.
module rtc_calib
  import rtc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        osc_edge,
  input  wire logic        sleep_mode,
  output logic             irq,
  output logic             wake,
  output logic             clock_pin,
  output logic             clock_pin_oe,
  output logic             level_select
);

  trim_if t ();

  logic [15:0] cfg_trim;
  logic [15:0] alarm_cfg;
  logic [1:0]  pad;
  logic [2:0]  int_status;
  logic [2:0]  int_mask;
  logic [7:0]  sec;
  logic [7:0]  min;
  logic [15:0] alarm_ms;
  logic        alarm_evt;
  logic        tick_d;

  logic        done;
  logic        wr;
  logic        rd;
  logic        answer;
  logic        hit_alarm;
  logic        hit_acfg;
  logic        hit_time;
  logic        hit_cfg;
  logic        hit_pad;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic [15:0] be16;
  logic [1:0]  tptr;
  logic [1:0]  aptr;
  logic        time_wr;
  logic        upper_touch;
  logic        mem_we;
  logic [2:0]  mem_waddr;
  logic [2:0]  mem_raddr;
  logic [15:0] mem_rdata;
  logic [15:0] rd_word;
  logic [2:0]  next_status;
  logic [2:0]  clr;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == SEC_LAST) begin
      return 8'h00;
    end else if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end else begin
      return v + 8'h01;
    end
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  trim_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (t.presc)
  );

  window_mem u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (pwdata[15:0]),
    .wbe   (pstrb[1:0]),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  assign t.osc_edge    = osc_edge;
  assign t.run         = cfg_trim[B_RUN_EN];
  assign t.cal         = cfg_trim[7:0];
  assign t.minute_wrap = t.second_tick && sec == SEC_LAST;

  assign done      = psel && penable && pready;
  assign wr        = done && pwrite;
  assign rd        = done && !pwrite;
  assign answer    = psel && penable && !pready;
  assign hit_alarm = paddr == OFF_ALARM_VALUE;
  assign hit_acfg  = paddr == OFF_ALARM_CFG;
  assign hit_time  = paddr == OFF_TIME_VALUE;
  assign hit_cfg   = paddr == OFF_CFG_TRIM;
  assign hit_pad   = paddr == OFF_PAD;
  assign hit_stat  = paddr == OFF_INT_STATUS;
  assign hit_mask  = paddr == OFF_INT_MASK;
  assign hit_any   = hit_alarm || hit_acfg || hit_time || hit_cfg || hit_pad || hit_stat || hit_mask;
  assign be16      = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign tptr      = cfg_trim[9:8];
  assign aptr      = alarm_cfg[9:8];

  // Time words are written only while software has unlocked them.
  assign time_wr     = wr && hit_time && cfg_trim[B_UNLOCK];
  assign upper_touch = rd || (wr && pstrb[1]);
  assign mem_we      = (wr && hit_alarm) || (time_wr && tptr != 2'h0);
  assign mem_waddr   = hit_time ? {1'b1, tptr} : {1'b0, aptr};
  assign mem_raddr   = hit_time ? {1'b1, tptr} : {1'b0, aptr};

  // Read data with unimplemented bits forced to zero, except alarm configuration bits 13:10, which read back as written.
  always_comb begin
    rd_word = 16'h0000;
    if (hit_alarm) begin
      rd_word = mem_rdata;
    end else if (hit_acfg) begin
      rd_word = alarm_cfg;
    end else if (hit_time) begin
      if (tptr == 2'h0) begin
        rd_word = {min, sec};
      end else if (tptr == 2'h3) begin
        rd_word = {8'h00, mem_rdata[7:0]};
      end else begin
        rd_word = mem_rdata;
      end
    end else if (hit_cfg) begin
      rd_word = {cfg_trim[15], 1'b0, cfg_trim[13], t.rollover_pending, t.half_second,
                 cfg_trim[10:0]};
    end else if (hit_pad) begin
      rd_word = {14'h0000, pad};
    end else if (hit_stat) begin
      rd_word = {13'h0000, int_status};
    end else if (hit_mask) begin
      rd_word = {13'h0000, int_mask};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= answer;
      pslverr <= answer && !hit_any;
      if (answer) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // Control register; the time pointer steps down on each upper-byte window access until it reaches zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_trim <= CFG_TRIM_RST;
    end else if (wr && hit_cfg) begin
      cfg_trim <= merge(cfg_trim, pwdata[15:0], be16 & CFG_WR_MASK);
    end else if (done && hit_time && upper_touch && tptr != 2'h0) begin
      cfg_trim[9:8] <= tptr - 2'h1;
    end
  end

  // Alarm configuration with one-shot and repeat handling.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_cfg <= ALARM_CFG_RST;
    end else if (wr && hit_acfg) begin
      alarm_cfg <= merge(alarm_cfg, pwdata[15:0], be16);
    end else if (alarm_evt) begin
      alarm_cfg[7:0] <= alarm_cfg[7:0] - 8'h01;
      if (!alarm_cfg[B_CHIME] && alarm_cfg[7:0] == 8'h00) begin
        alarm_cfg[B_AL_EN] <= 1'b0;
        alarm_cfg[7:0]     <= 8'h00;
      end
    end else if (done && hit_alarm && upper_touch && aptr != 2'h0) begin
      alarm_cfg[9:8] <= aptr - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad <= PAD_RST;
    end else if (wr && hit_pad && pstrb[0]) begin
      pad <= pwdata[1:0];
    end
  end

  // Window contents carry no reset.
  always_ff @(posedge pclk) begin
    if (wr && hit_alarm && aptr == 2'h0) begin
      alarm_ms <= merge(alarm_ms, pwdata[15:0], be16);
    end
  end

  // Seconds and minutes run from the oscillator tick alone, whatever the power mode.
  always_ff @(posedge pclk) begin
    if (time_wr && tptr == 2'h0) begin
      sec <= pstrb[0] ? pwdata[7:0] : sec;
      min <= pstrb[1] ? pwdata[15:8] : min;
    end else if (t.second_tick) begin
      sec <= bcd_inc(sec);
      if (sec == SEC_LAST) begin
        min <= bcd_inc(min);
      end
    end
  end

  // Alarm compares minutes and seconds once after every seconds tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d    <= 1'b0;
      alarm_evt <= 1'b0;
    end else begin
      tick_d    <= t.second_tick;
      alarm_evt <= tick_d && alarm_cfg[B_AL_EN] && {min, sec} == alarm_ms;
    end
  end

  // Sticky status, where a new event wins over a write-one clear.
  assign clr         = (wr && hit_stat && pstrb[0]) ? pwdata[2:0] : 3'h0;
  assign next_status = (int_status & ~clr) | {t.trim_applied, t.second_tick, alarm_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= INT_RST;
      int_mask   <= INT_RST;
    end else begin
      int_status <= next_status;
      if (wr && hit_mask && pstrb[0]) begin
        int_mask <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= |(int_status & int_mask);
      wake <= sleep_mode && int_status[I_ALARM] && int_mask[I_ALARM];
    end
  end

  // Clock pin shows the seconds square wave or toggles on each alarm.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_pin    <= 1'b0;
      clock_pin_oe <= 1'b0;
      level_select <= 1'b0;
    end else begin
      clock_pin_oe <= cfg_trim[B_PIN_OE];
      level_select <= pad[B_LEVEL_SEL];
      if (pad[B_SEC_SEL]) begin
        clock_pin <= t.half_second;
      end else if (alarm_evt) begin
        clock_pin <= !clock_pin;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sec_pin;
    pad[B_SEC_SEL] |=> clock_pin == $past(t.half_second);
  endproperty
  property p_wake;
    alarm_evt && int_mask[I_ALARM] ##1 sleep_mode && int_mask[I_ALARM] |=> wake;
  endproperty
  property p_count;
    t.second_tick && !time_wr |=> sec != $past(sec) && sec == bcd_inc($past(sec));
  endproperty
  property p_reset_cfg;
    $past(!presetn) |-> cfg_trim == CFG_TRIM_RST && alarm_cfg == ALARM_CFG_RST && pad == PAD_RST;
  endproperty
  property p_reserved;
    pready && !pwrite && psel && (hit_pad || hit_stat || hit_mask) |-> prdata[31:3] == 29'h0;
  endproperty

  a_sec_pin:   assert property (p_sec_pin) else $error("Seconds clock missing on pin.");
  a_wake:      assert property (p_wake) else $error("Alarm did not wake.");
  a_count:     assert property (p_count) else $error("Seconds did not advance.");
  a_reset_cfg: assert property (p_reset_cfg) else $error("Control not cleared by reset.");
  a_reserved:  assert property (p_reserved) else $error("Unused bits read nonzero.");
  c_wake:      cover property (wake);
  c_alarm_pin: cover property (alarm_evt && !pad[B_SEC_SEL]);

  // Status capture, wake gating, pin enable and read-back zeros.
  property p_alarm_status;
    alarm_evt |=> int_status[I_ALARM];
  endproperty
  property p_no_wake;
    !sleep_mode |=> !wake;
  endproperty
  property p_oe_follow;
    1'b1 |=> clock_pin_oe == $past(cfg_trim[B_PIN_OE]);
  endproperty
  property p_cfg_zero;
    pready && !pwrite && psel && hit_cfg |-> prdata[31:16] == 16'h0000 && !prdata[14];
  endproperty
  property p_ptr3_zero;
    pready && !pwrite && psel && hit_time && tptr == 2'h3 |-> prdata[15:8] == 8'h00;
  endproperty
  property p_unmapped;
    pready && psel && !hit_any |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  property p_trim_status;
    t.trim_applied |=> int_status[I_TRIM];
  endproperty

  a_alarm_status: assert property (p_alarm_status) else $error("Alarm event not captured.");
  a_no_wake:      assert property (p_no_wake) else $error("Wake outside sleep.");
  a_oe_follow:    assert property (p_oe_follow) else $error("Pin enable not following control.");
  a_cfg_zero:     assert property (p_cfg_zero) else $error("Control unused bits nonzero.");
  a_ptr3_zero:    assert property (p_ptr3_zero) else $error("Top time word upper byte nonzero.");
  a_unmapped:     assert property (p_unmapped) else $error("Unmapped access not refused.");
  a_trim_status:  assert property (p_trim_status) else $error("Trim event not captured.");
  c_cal_write:    cover property (wr && hit_cfg && t.half_second);
endmodule

//--- dv/rtc_calib_test.sv
// Self-checking testbench of the clock calibration block, driven over APB.
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module rtc_calib_test;
  import rtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TIMEOUT  = 90000;
  localparam int FERR_MHZ = -200;
  localparam int TRIM_VAL = FERR_MHZ * 60 / 1000 / 4;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        osc_edge;
  logic        sleep_mode;
  logic        irq;
  logic        wake;
  logic        clock_pin;
  logic        clock_pin_oe;
  logic        level_select;
  int          n_errors;
  int          n_checks;
  int          cyc;
  int          n_rise;
  int          stamp [2];
  int          pin_changes;
  logic        irq_q;
  logic        pin_q;
  logic [31:0] rd;
  logic        err;

  rtc_calib dut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .osc_edge     (osc_edge),
    .sleep_mode   (sleep_mode),
    .irq          (irq),
    .wake         (wake),
    .clock_pin    (clock_pin),
    .clock_pin_oe (clock_pin_oe),
    .level_select (level_select)
  );

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  // Time stamps of interrupt rises and activity of the clock pin between them.
  always @(posedge pclk) begin
    cyc++;
    irq_q <= irq;
    pin_q <= clock_pin;
    if (irq === 1'b1 && irq_q === 1'b0 && n_rise < 2) begin
      stamp[n_rise] = cyc;
      n_rise++;
    end
    if (n_rise == 1 && clock_pin !== pin_q) begin
      pin_changes++;
    end
    if (cyc == TIMEOUT) begin
      n_errors++;
      $display("ERROR timeout after %0d cycles", cyc);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_reset_values();
    apb(1'b0, OFF_CFG_TRIM, 32'h0);
    `CHK("cfg_trim", 32'h00000000, rd)
    apb(1'b0, OFF_ALARM_CFG, 32'h0);
    `CHK("alarm_cfg", 32'h00000000, rd)
    apb(1'b0, OFF_PAD, 32'h0);
    `CHK("pad_config", 32'h00000000, rd)
    apb(1'b0, OFF_INT_MASK, 32'h0);
    `CHK("int_mask", 32'h00000000, rd)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h00000000, rd)
    `CHK("irq", 1'b0, irq)
    `CHK("oe", 1'b0, clock_pin_oe)
    $display("test reset_values done");
  endtask

  task automatic test_unused_bits();
    apb(1'b1, OFF_CFG_TRIM, 32'hFFFFFFFF);
    apb(1'b0, OFF_CFG_TRIM, 32'h0);
    `CHK("cfg_trim_ones", 32'h0000A7FF, rd)
    `CHK("pin_oe", 1'b1, clock_pin_oe)
    apb(1'b1, OFF_PAD, 32'hFFFFFFFF);
    apb(1'b0, OFF_PAD, 32'h0);
    `CHK("pad_ones", 32'h00000003, rd)
    `CHK("level_select", 1'b1, level_select)
    apb(1'b1, OFF_CFG_TRIM, 32'h0);
    apb(1'b1, OFF_PAD, 32'h00000002);
    $display("test unused_bits done");
  endtask

  task automatic test_windows();
    apb(1'b1, OFF_CFG_TRIM, 32'h00002300);
    apb(1'b1, OFF_TIME_VALUE, 32'h0000ABCD);
    apb(1'b0, OFF_CFG_TRIM, 32'h0);
    `CHK("time_ptr_step", 2'h2, rd[9:8])
    apb(1'b1, OFF_CFG_TRIM, 32'h00000300);
    apb(1'b1, OFF_TIME_VALUE, 32'h00001234);
    apb(1'b1, OFF_CFG_TRIM, 32'h00000300);
    apb(1'b0, OFF_TIME_VALUE, 32'h0);
    `CHK("time_ptr3_read", 32'h000000CD, rd)
    apb(1'b1, OFF_ALARM_CFG, 32'h00000200);
    apb(1'b1, OFF_ALARM_VALUE, 32'h00005A5A);
    apb(1'b1, OFF_ALARM_CFG, 32'h00000200);
    apb(1'b0, OFF_ALARM_VALUE, 32'h0);
    `CHK("alarm_window", 32'h00005A5A, rd)
    apb(1'b1, OFF_ALARM_CFG, 32'h0);
    apb(1'b1, 8'h1C, 32'h0);
    `CHK("unmapped_wr_err", 1'b1, err)
    $display("test windows done");
  endtask

  task automatic test_trim_minute();
    int n;
    apb(1'b1, OFF_CFG_TRIM, 32'h00002000);
    apb(1'b1, OFF_TIME_VALUE, 32'h00000059);
    apb(1'b1, OFF_ALARM_VALUE, 32'h00000100);
    apb(1'b1, OFF_ALARM_CFG, 32'h00008000);
    apb(1'b1, OFF_INT_MASK, 32'h00000003);
    sleep_mode <= 1'b1;
    osc_edge   <= 1'b1;
    apb(1'b1, OFF_CFG_TRIM, {16'h0, 8'hA4, 8'(TRIM_VAL)});
    wait (n_rise == 1);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    `CHK("status_tick_alarm", 32'h00000003, rd)
    `CHK("wake", 1'b1, wake)
    apb(1'b1, OFF_INT_STATUS, 32'h00000007);
    sleep_mode <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, OFF_CFG_TRIM, 32'h0);
      n++;
    end while (rd[11] !== 1'b1 && n < 20000);
    `CHK("half_second", 1'b1, rd[11])
    `CHK("rollover_pending", 1'b0, rd[12])
    apb(1'b1, OFF_CFG_TRIM, 32'h0000A400);
    wait (n_rise == 2);
    `CHK("trimmed_period", OSC_HZ - TRIM_STEP * TRIM_VAL, stamp[1] - stamp[0])
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    `CHK("status_trim", 32'h00000006, rd)
    apb(1'b0, OFF_TIME_VALUE, 32'h0);
    `CHK("time_window", 32'h00000101, rd)
    apb(1'b0, OFF_ALARM_CFG, 32'h0);
    `CHK("alarm_one_shot", 32'h00000000, rd)
    `CHK("pin_toggles", 1'b1, pin_changes != 0)
    $display("test trim_minute done");
  endtask

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    osc_edge    = 1'b0;
    sleep_mode  = 1'b0;
    n_errors    = 0;
    n_checks    = 0;
    cyc         = 0;
    n_rise      = 0;
    pin_changes = 0;
    irq_q       = 1'b0;
    pin_q       = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_reset_values();
    test_unused_bits();
    test_windows();
    test_trim_minute();
    summarize();
  end
endmodule
